// ### verilog/tccl_pkg.sv
// constants for the timer control decode and compare load block
// Operation
// (R1) start field 00 stops and clears counter
// (R2) start field 01 starts on command
// (R3) start field 10 rising edge / high level
// (R4) start field 11 falling edge / low level
// (R5) clock select divides by 2^11, 2^7, 2^3, pin
// (R6) mode select picks timer, window, pulse-measure; pulse-measure here counts like the timer
// (R7) compare value active at next source edge
// (R8) lower byte write alone changes nothing active
// (R9) software writes lower byte before upper byte
// (R10) software changes settings only while stopped
// (R11) stop state forces start field to 00
// (R12) buffered lower byte held until commit
`default_nettype none
package tccl_pkg;
   // start-control codes
   localparam logic [1:0] START_STOP = 2'h0;
   localparam logic [1:0] START_CMD = 2'h1;
   localparam logic [1:0] START_RISE = 2'h2;
   localparam logic [1:0] START_FALL = 2'h3;
   // count clock select codes
   localparam logic [1:0] CLK_DIV11 = 2'h0;
   localparam logic [1:0] CLK_DIV7 = 2'h1;
   localparam logic [1:0] CLK_DIV3 = 2'h2;
   localparam logic [1:0] CLK_PIN = 2'h3;
   localparam int DIV11_BIT = 10;
   localparam int DIV7_BIT = 6;
   localparam int DIV3_BIT = 2;
   localparam int PRESCALE_W = 11;
   // operating mode codes
   localparam logic [1:0] MODE_TIMER = 2'h0;
   localparam logic [1:0] MODE_WINDOW = 2'h1;
   localparam logic [1:0] MODE_PULSE = 2'h2;
   localparam logic [1:0] MODE_PPG = 2'h3;
   // values after reset
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COMPARE_RESET = 16'hffff;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   typedef enum logic [2:0] {
      TCCL_IDLE = 3'b001,
      TCCL_ARMED = 3'b010,
      TCCL_RUN = 3'b100
   } tccl_state_t;
endpackage : tccl_pkg
`default_nettype wire

// ### verilog/tccl_compare_stage.sv
// two-stage compare register: written buffer and active value
`default_nettype none
module tccl_compare_stage #(
   parameter int WIDTH = 16
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic lowWrite,
   input wire logic highWrite,
   input wire logic [7:0] writeData,
   input wire logic sourceTick,
   output logic [WIDTH-1:0] activeValue,
   output logic [WIDTH-1:0] bufferValue
);
   logic [7:0] lowByte_reg, lowByte_next;
   logic [7:0] highByte_reg, highByte_next;
   logic pending_reg, pending_next;
   logic [WIDTH-1:0] active_reg, active_next;

   always_comb
   begin
      lowByte_next = lowByte_reg;
      highByte_next = highByte_reg;
      pending_next = pending_reg;
      active_next = active_reg;
      // (R12) lower byte held
      if (lowWrite)
      begin
         lowByte_next = writeData;
      end
      // (R8) only upper byte arms
      if (highWrite)
      begin
         highByte_next = writeData;
         pending_next = 1'b1;
      end
      // (R7) commit at source edge
      if (pending_reg && sourceTick && !highWrite)
      begin
         active_next = WIDTH'({highByte_reg, lowByte_reg});
         pending_next = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         lowByte_reg <= tccl_pkg::BYTE_RESET;
         highByte_reg <= tccl_pkg::BYTE_RESET;
         pending_reg <= 1'b0;
         active_reg <= WIDTH'(tccl_pkg::COMPARE_RESET);
      end
      else
      begin
         lowByte_reg <= lowByte_next;
         highByte_reg <= highByte_next;
         pending_reg <= pending_next;
         active_reg <= active_next;
      end
   end

   assign activeValue = active_reg;
   assign bufferValue = WIDTH'({highByte_reg, lowByte_reg});

   // (R8) low write keeps active
   property p_low_only;
      @(posedge mclk) disable iff (!reset_n)
      (lowWrite && !pending_reg && !highWrite) |=> $stable(active_reg);
   endproperty
   a_low_only: assert property (p_low_only) else $error("active changed by low write"); // R8
   property p_commit;
      @(posedge mclk) disable iff (!reset_n)
      (pending_reg && sourceTick && !highWrite) |=> (active_reg == $past(bufferValue));
   endproperty
   a_commit: assert property (p_commit) else $error("compare value not committed"); // R7
   property p_no_tick;
      @(posedge mclk) disable iff (!reset_n)
      !sourceTick |=> $stable(active_reg);
   endproperty
   a_no_tick: assert property (p_no_tick) else $error("active changed off tick"); // R7
   property p_low_hold;
      @(posedge mclk) disable iff (!reset_n)
      !lowWrite |=> $stable(lowByte_reg);
   endproperty
   a_low_hold: assert property (p_low_hold) else $error("lower byte changed"); // R12
endmodule : tccl_compare_stage
`default_nettype wire

// ### verilog/tccl_timer_control.sv
// control decode, source clock select and compare loading for the timer
`default_nettype none
module tccl_timer_control (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic controlWrite,
   input wire logic [1:0] startControlIn,
   input wire logic [1:0] countClockSelectIn,
   input wire logic [1:0] operatingModeSelectIn,
   input wire logic stopModeEnter,
   input wire logic timerInputPin,
   input wire logic periodLowWrite,
   input wire logic periodHighWrite,
   input wire logic secondLowWrite,
   input wire logic secondHighWrite,
   input wire logic [7:0] writeData,
   output logic [1:0] startControlField,
   output logic [1:0] countClockSelect,
   output logic [1:0] operatingModeSelect,
   output logic [15:0] upCounter,
   output logic counting,
   output logic sourceTick,
   output logic [15:0] periodCompare,
   output logic [15:0] secondCompare
);
   // =========================================
   // control register
   logic [1:0] start_reg, start_next;
   logic [1:0] clkSel_reg, clkSel_next;
   logic [1:0] mode_reg, mode_next;

   always_comb
   begin
      start_next = start_reg;
      clkSel_next = clkSel_reg;
      mode_next = mode_reg;
      if (controlWrite)
      begin
         start_next = startControlIn;
         // (R10) settings only while stopped
         if (start_reg == tccl_pkg::START_STOP)
         begin
            clkSel_next = countClockSelectIn;
            mode_next = operatingModeSelectIn;
         end
      end
      // (R11) stop state forces stop
      if (stopModeEnter)
      begin
         start_next = tccl_pkg::START_STOP;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         start_reg <= tccl_pkg::START_STOP;
         clkSel_reg <= tccl_pkg::CLK_DIV11;
         mode_reg <= tccl_pkg::MODE_TIMER;
      end
      else
      begin
         start_reg <= start_next;
         clkSel_reg <= clkSel_next;
         mode_reg <= mode_next;
      end
   end

   // =========================================
   // prescaler and source clock
   logic [tccl_pkg::PRESCALE_W-1:0] pre_reg, pre_next;
   logic pinPrev_reg, pinPrev_next;
   logic tick_reg, tick_next;
   logic pinRise, pinFall, preTick;

   assign pinRise = timerInputPin && !pinPrev_reg;
   assign pinFall = !timerInputPin && pinPrev_reg;

   // (R5) clock source select
   always_comb
   begin
      pre_next = pre_reg + 1'b1;
      pinPrev_next = timerInputPin;
      case (clkSel_reg)
         tccl_pkg::CLK_DIV11: preTick = &pre_reg[tccl_pkg::DIV11_BIT:0];
         tccl_pkg::CLK_DIV7: preTick = &pre_reg[tccl_pkg::DIV7_BIT:0];
         tccl_pkg::CLK_DIV3: preTick = &pre_reg[tccl_pkg::DIV3_BIT:0];
         default: preTick = pinRise;
      endcase
      tick_next = preTick;
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         pre_reg <= '0;
         pinPrev_reg <= 1'b0;
         tick_reg <= 1'b0;
      end
      else
      begin
         pre_reg <= pre_next;
         pinPrev_reg <= pinPrev_next;
         tick_reg <= tick_next;
      end
   end

   // =========================================
   // start sequencing and up-counter
   tccl_pkg::tccl_state_t state_reg, state_next;
   logic [15:0] count_reg, count_next;
   logic startEdge, eventEdge, windowLevel, isEvent;

   // (R6) mode select decode
   // external pin as count clock means event counting in the timer group
   assign isEvent = (mode_reg == tccl_pkg::MODE_TIMER) && (clkSel_reg == tccl_pkg::CLK_PIN);
   // (R3) (R4) edge and level polarity
   assign startEdge = (start_reg == tccl_pkg::START_RISE) ? pinRise : pinFall;
   assign eventEdge = startEdge;
   assign windowLevel = (start_reg == tccl_pkg::START_RISE) ? timerInputPin : !timerInputPin;

   always_comb
   begin
      state_next = state_reg;
      count_next = count_reg;
      case (state_reg)
         tccl_pkg::TCCL_IDLE:
         begin
            if (start_reg != tccl_pkg::START_STOP)
            begin
               state_next = tccl_pkg::TCCL_ARMED;
            end
         end
         tccl_pkg::TCCL_ARMED:
         begin
            // (R2) command start
            if (start_reg == tccl_pkg::START_CMD)
            begin
               state_next = tccl_pkg::TCCL_RUN;
            end
            else if (isEvent || mode_reg == tccl_pkg::MODE_WINDOW || startEdge)
            begin
               state_next = tccl_pkg::TCCL_RUN;
            end
         end
         tccl_pkg::TCCL_RUN:
         begin
            if (isEvent)
            begin
               if (eventEdge)
               begin
                  count_next = count_reg + 16'h0001;
               end
            end
            else if (mode_reg == tccl_pkg::MODE_WINDOW && start_reg != tccl_pkg::START_CMD)
            begin
               if (tick_reg && windowLevel)
               begin
                  count_next = count_reg + 16'h0001;
               end
            end
            else if (tick_reg)
            begin
               count_next = count_reg + 16'h0001;
            end
         end
         default:
         begin
            state_next = tccl_pkg::TCCL_IDLE;
         end
      endcase
      // (R1) stop and clear
      if (start_reg == tccl_pkg::START_STOP)
      begin
         state_next = tccl_pkg::TCCL_IDLE;
         count_next = tccl_pkg::COUNT_RESET;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         state_reg <= tccl_pkg::TCCL_IDLE;
         count_reg <= tccl_pkg::COUNT_RESET;
      end
      else
      begin
         state_reg <= state_next;
         count_reg <= count_next;
      end
   end

   // =========================================
   // compare registers
   // (R9) software orders low then high
   tccl_compare_stage #(.WIDTH(16)) periodStage (
      .mclk(mclk),
      .reset_n(reset_n),
      .lowWrite(periodLowWrite),
      .highWrite(periodHighWrite),
      .writeData(writeData),
      .sourceTick(tick_reg),
      .activeValue(periodCompare),
      .bufferValue()
   );
   tccl_compare_stage #(.WIDTH(16)) secondStage (
      .mclk(mclk),
      .reset_n(reset_n),
      .lowWrite(secondLowWrite),
      .highWrite(secondHighWrite),
      .writeData(writeData),
      .sourceTick(tick_reg),
      .activeValue(secondCompare),
      .bufferValue()
   );

   assign startControlField = start_reg;
   assign countClockSelect = clkSel_reg;
   assign operatingModeSelect = mode_reg;
   assign upCounter = count_reg;
   assign counting = state_reg == tccl_pkg::TCCL_RUN;
   assign sourceTick = tick_reg;

   // (R1) stopped counter cleared
   property p_stop_clear;
      @(posedge mclk) disable iff (!reset_n)
      (start_reg == tccl_pkg::START_STOP) |=> (count_reg == 16'h0000);
   endproperty
   a_stop_clear: assert property (p_stop_clear) else $error("counter not cleared"); // R1
   property p_cmd_start;
      @(posedge mclk) disable iff (!reset_n)
      (state_reg == tccl_pkg::TCCL_ARMED && start_reg == tccl_pkg::START_CMD && !stopModeEnter
       && !controlWrite) |=> (state_reg == tccl_pkg::TCCL_RUN);
   endproperty
   a_cmd_start: assert property (p_cmd_start) else $error("command start missed"); // R2
   property p_stop_force;
      @(posedge mclk) disable iff (!reset_n)
      stopModeEnter |=> (start_reg == tccl_pkg::START_STOP);
   endproperty
   a_stop_force: assert property (p_stop_force) else $error("stop not forced"); // R11
   property p_settings_locked;
      @(posedge mclk) disable iff (!reset_n)
      (start_reg != tccl_pkg::START_STOP) |=> $stable(clkSel_reg) && $stable(mode_reg);
   endproperty
   a_settings_locked: assert property (p_settings_locked) else $error("settings changed"); // R10
   property p_div3;
      @(posedge mclk) disable iff (!reset_n)
      (clkSel_reg == tccl_pkg::CLK_DIV3 && tick_reg && $stable(clkSel_reg))
      |=> !tick_reg [*7];
   endproperty
   a_div3: assert property (p_div3) else $error("divide by 8 tick spacing"); // R5
   property p_window;
      @(posedge mclk) disable iff (!reset_n)
      (state_reg == tccl_pkg::TCCL_RUN && mode_reg == tccl_pkg::MODE_WINDOW
       && start_reg == tccl_pkg::START_RISE && !timerInputPin) |=> $stable(count_reg);
   endproperty
   a_window: assert property (p_window) else $error("window counted while low"); // R3
   property p_fall_event;
      @(posedge mclk) disable iff (!reset_n)
      (state_reg == tccl_pkg::TCCL_RUN && isEvent && start_reg == tccl_pkg::START_FALL
       && pinFall) |=> (count_reg == $past(count_reg) + 16'h0001);
   endproperty
   a_fall_event: assert property (p_fall_event) else $error("falling edge not counted"); // R4
endmodule : tccl_timer_control
`default_nettype wire

// ### verif/tccl_pin_source.sv
// partner model: source of the external timer input pin
`default_nettype none
module tccl_pin_source (
   input wire logic mclk,
   input wire logic toggleEn,
   input wire logic idleLevel,
   output var logic timerInputPin,
   output var logic [7:0] riseCount,
   output var logic [7:0] fallCount
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase_reg = 2'h0;
   logic pin_reg = 1'b0;
   logic [7:0] rise_reg = 8'h00;
   logic [7:0] fall_reg = 8'h00;
   assign timerInputPin = pin_reg;
   assign riseCount = rise_reg;
   assign fallCount = fall_reg;
   // =====================================================
   // pin waveform
   // toggles every 4 cycles, slow enough for the pin edge detector
   always @(posedge mclk)
   begin
      phase_reg <= phase_reg + 2'h1;
      if (toggleEn ? (phase_reg == 2'h3) : (pin_reg != idleLevel))
      begin
         pin_reg <= !pin_reg;
         rise_reg <= rise_reg + {7'h00, !pin_reg};
         fall_reg <= fall_reg + {7'h00, pin_reg};
      end
   end
endmodule : tccl_pin_source
`default_nettype wire

// ### verif/tccl_timer_control_tb.sv
// self-checking testbench for the timer control and compare load block
`default_nettype none
`define CHK(a, e, m) begin total_checks++; if ((a) !== (e)) begin errors++; \
   $display("CHECK FAILED t=%0t %s", $time, m); end end
module tccl_timer_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic controlWrite = 1'b0, stopModeEnter = 1'b0;
   logic [1:0] startIn = 2'h0, clkIn = 2'h0, modeIn = 2'h0;
   logic pLow = 1'b0, pHigh = 1'b0, sLow = 1'b0, sHigh = 1'b0;
   logic [7:0] writeData = 8'h00;
   logic toggleEn = 1'b0, idleLevel = 1'b0, pin;
   logic [7:0] riseCount, fallCount, rise0, fall0;
   logic [1:0] startF, clkF, modeF;
   logic [15:0] upCounter, periodCompare, secondCompare;
   logic counting, sourceTick;
   int errors = 0, total_checks = 0, n;
   logic [5:0] rows [6] = '{6'h31, 6'h20, 6'h16, 6'h06, 6'h26, 6'h3f};
   logic [5:0] exps [6] = '{6'h31, 6'h21, 6'h11, 6'h01, 6'h26, 6'h36};
   always #2.5 mclk = !mclk;
   tccl_pin_source u_pin (.mclk(mclk), .toggleEn(toggleEn), .idleLevel(idleLevel),
      .timerInputPin(pin), .riseCount(riseCount), .fallCount(fallCount));
   tccl_timer_control u_dut (.mclk(mclk), .reset_n(reset_n), .controlWrite(controlWrite),
      .startControlIn(startIn), .countClockSelectIn(clkIn), .operatingModeSelectIn(modeIn),
      .stopModeEnter(stopModeEnter), .timerInputPin(pin), .periodLowWrite(pLow),
      .periodHighWrite(pHigh), .secondLowWrite(sLow), .secondHighWrite(sHigh),
      .writeData(writeData), .startControlField(startF), .countClockSelect(clkF),
      .operatingModeSelect(modeF), .upCounter(upCounter), .counting(counting),
      .sourceTick(sourceTick), .periodCompare(periodCompare), .secondCompare(secondCompare));
   // =====================================================
   // tasks
   task automatic wr(input logic [1:0] s, input logic [1:0] c, input logic [1:0] m);
      @(posedge mclk);
      controlWrite <= 1'b1;
      startIn <= s;
      clkIn <= c;
      modeIn <= m;
      @(posedge mclk);
      controlWrite <= 1'b0;
      #1;
   endtask : wr
   task automatic waitTick();
      for (int i = 0; i < 5000 && sourceTick !== 1'b1; i++)
      begin
         @(posedge mclk);
         #1;
      end
   endtask : waitTick
   task automatic byteWr(input logic sel, input logic high, input logic [7:0] d);
      @(posedge mclk);
      pLow <= !sel && !high;
      pHigh <= !sel && high;
      sLow <= sel && !high;
      sHigh <= sel && high;
      writeData <= d;
      @(posedge mclk);
      {pLow, pHigh, sLow, sHigh} <= 4'h0;
      #1;
   endtask : byteWr
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done
   initial
   begin
      repeat (60000) @(posedge mclk);
      errors++;
      test_done();
   end
   // =====================================================
   // main sequence
   initial
   begin
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      #1;
      `CHK({startF, clkF, modeF, counting}, 7'h00, "reset fields")
      `CHK({upCounter, periodCompare, secondCompare}, 48'h0000_ffff_ffff, "reset values")
      $display("test reset done");
      // settings change only while stopped; all rows but the first and the fifth try it while running
      for (int r = 0; r < 6; r++)
      begin
         wr(rows[r][5:4], rows[r][3:2], rows[r][1:0]);
         `CHK({startF, clkF, modeF}, exps[r], "control fields")
      end
      wr(2'h0, 2'h0, 2'h0);
      $display("test control table done");
      for (int c = 0; c < 3; c++)
      begin
         wr(2'h0, c[1:0], tccl_pkg::MODE_TIMER);
         wr(tccl_pkg::START_CMD, c[1:0], tccl_pkg::MODE_TIMER);
         waitTick();
         @(posedge mclk);
         #1;
         n = 1;
         while (sourceTick !== 1'b1 && n < 3000)
         begin
            @(posedge mclk);
            #1;
            n++;
         end
         `CHK(n, 2 ** (11 - 4 * c), "tick spacing")
         `CHK(counting, 1'b1, "command start")
         wr(2'h0, c[1:0], tccl_pkg::MODE_TIMER);
         // the clear follows the stored stop code by one cycle
         @(posedge mclk);
         #1;
         `CHK({counting, upCounter}, 17'h0, "stop clears")
      end
      $display("test clock select done");
      wr(tccl_pkg::START_CMD, tccl_pkg::CLK_DIV3, tccl_pkg::MODE_TIMER);
      for (int s = 0; s < 2; s++)
      begin
         // lower byte first, upper byte second
         byteWr(s[0], 1'b0, 8'h5a);
         repeat (40) @(posedge mclk);
         #1;
         `CHK(s ? secondCompare : periodCompare, 16'hffff, "lone low byte")
         byteWr(s[0], 1'b1, 8'ha5);
         `CHK(s ? secondCompare : periodCompare, 16'hffff, "early load")
         waitTick();
         @(posedge mclk);
         #1;
         `CHK(s ? secondCompare : periodCompare, 16'ha55a, "compare load")
      end
      $display("test compare load done");
      repeat (20) @(posedge mclk);
      stopModeEnter <= 1'b1;
      @(posedge mclk);
      stopModeEnter <= 1'b0;
      @(posedge mclk);
      #1;
      `CHK({startF, counting, upCounter}, 19'h0, "stop state entry")
      $display("test stop state done");
      for (int s = 2; s < 4; s++)
      begin
         wr(2'h0, tccl_pkg::CLK_PIN, tccl_pkg::MODE_TIMER);
         wr(s[1:0], tccl_pkg::CLK_PIN, tccl_pkg::MODE_TIMER);
         // edges before the run state are not counted, so hold the pin until then
         @(posedge mclk);
         rise0 = riseCount;
         fall0 = fallCount;
         toggleEn <= 1'b1;
         repeat (80) @(posedge mclk);
         toggleEn <= 1'b0;
         repeat (12) @(posedge mclk);
         #1;
         `CHK(upCounter, {8'h00, s == 2 ? riseCount - rise0 : fallCount - fall0}, "edge count")
      end
      $display("test event count done");
      for (int s = 2; s < 4; s++)
      begin
         wr(2'h0, tccl_pkg::CLK_DIV3, tccl_pkg::MODE_WINDOW);
         idleLevel <= s[0];
         wr(s[1:0], tccl_pkg::CLK_DIV3, tccl_pkg::MODE_WINDOW);
         repeat (100) @(posedge mclk);
         #1;
         `CHK(upCounter, 16'h0000, "window closed")
         idleLevel <= !s[0];
         repeat (100) @(posedge mclk);
         #1;
         `CHK(upCounter > 16'h0008, 1'b1, "window open")
      end
      $display("test window done");
      // external trigger: armed timer waits for a rising pin edge
      wr(2'h0, tccl_pkg::CLK_DIV3, tccl_pkg::MODE_TIMER);
      wr(tccl_pkg::START_RISE, tccl_pkg::CLK_DIV3, tccl_pkg::MODE_TIMER);
      repeat (20) @(posedge mclk);
      idleLevel <= 1'b1;
      #1;
      `CHK({counting, upCounter}, 17'h0, "trigger armed")
      repeat (4) @(posedge mclk);
      #1;
      `CHK(counting, 1'b1, "trigger start")
      $display("test trigger done");
      test_done();
   end
endmodule : tccl_timer_control_tb
`undef CHK
`default_nettype wire
